// file: eii_bench.sv
// Self-checking bench for the external interrupt inputs
`timescale 1ns/1ns
module eii_bench
    import eii_pkg::*;
;
    // Clock, reset, bus and block outputs
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [EII_NUM_PINS-1:0] pin_in;
    logic [EII_NUM_PINS-1:0] pin_sel;
    logic [EII_NUM_CH-1:0] vic_req;
    logic wake_req;
    logic irq;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int num_checks = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    eii_top dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_sel(pin_sel), .vic_req(vic_req),
        .wake_req(wake_req), .irq(irq));

    eii_pin_model pm_u (.sys_clk(sys_clk), .pin_in(pin_in), .pin_sel(pin_sel));

    // Verdict and end of run
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Let pins cross the synchroniser and reach the flags
    task automatic settle;
        repeat (4) @(posedge sys_clk);
    endtask : settle

    // Main sequence
    initial begin
        int ch;
        logic rise;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset values, then an unmapped address
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, EII_OFF_FLAGS + 32'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, EII_OFF_FLAGS + 32'h14, 32'h0);
        check({31'h0, err}, 32'h1);
        // Active-low level: one low pin of two is enough
        pm_u.drive(9'h1ff, 9'h1ff);
        settle();
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h0);
        pm_u.drive(9'h1fe, 9'h1ff);
        settle();
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h1);
        check({28'h0, vic_req}, 32'h1);
        // Clearing while the pin is still active does not stick
        apb(1'b1, EII_OFF_FLAGS, 32'h1);
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h1);
        pm_u.drive(9'h1ff, 9'h1ff);
        settle();
        apb(1'b1, EII_OFF_FLAGS, 32'h1);
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h0);
        // Active-high level: one high pin sets only its channel
        apb(1'b1, EII_OFF_POL, 32'hf);
        pm_u.drive(9'h008, 9'h1ff);
        settle();
        apb(1'b1, EII_OFF_FLAGS, 32'hf);
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h2);
        check({28'h0, vic_req}, 32'h2);
        // Edge mode: every pin alone, rising on even pins, falling on odd
        apb(1'b1, EII_OFF_MODE, 32'hf);
        for (int p = 0; p < EII_NUM_PINS; p++) begin
            rise = ~p[0];
            ch = (p < 6) ? p / 2 : 3;
            apb(1'b1, EII_OFF_POL, {28'h0, {4{rise}}});
            pm_u.drive(rise ? 9'h000 : 9'h1ff, 9'(1 << p));
            settle();
            apb(1'b1, EII_OFF_FLAGS, 32'hf);
            pm_u.drive(rise ? 9'(1 << p) : ~9'(1 << p), 9'(1 << p));
            settle();
            apb(1'b0, EII_OFF_FLAGS, 32'h0);
            check(rd, 32'(1 << ch));
            check({28'h0, vic_req}, 32'(1 << ch));
        end
        // Edge mode with two pins selected follows the lower one
        pm_u.drive(9'h000, 9'h0c0);
        settle();
        apb(1'b1, EII_OFF_FLAGS, 32'hf);
        pm_u.drive(9'h080, 9'h0c0);
        settle();
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h0);
        pm_u.drive(9'h0c0, 9'h0c0);
        settle();
        apb(1'b1, EII_OFF_FLAGS, 32'h0);
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h8);
        // Mask gates the summary interrupt; wake follows its enable
        check({31'h0, irq}, 32'h0);
        check({31'h0, wake_req}, 32'h0);
        apb(1'b1, EII_OFF_MASK, 32'h8);
        apb(1'b1, EII_OFF_WAKE, 32'h8);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        check({31'h0, wake_req}, 32'h1);
        // Configuration reads back what was written
        apb(1'b0, EII_OFF_WAKE, 32'h0);
        check(rd, 32'h8);
        check({31'h0, err}, 32'h0);
        apb(1'b0, EII_OFF_MODE, 32'h0);
        check(rd, 32'hf);
        apb(1'b0, EII_OFF_POL, 32'h0);
        check(rd, 32'hf);
        apb(1'b0, EII_OFF_MASK, 32'h0);
        check(rd, 32'h8);
        apb(1'b1, EII_OFF_FLAGS, 32'h8);
        repeat (2) @(posedge sys_clk);
        apb(1'b0, EII_OFF_FLAGS, 32'h0);
        check(rd, 32'h0);
        check({24'h0, vic_req, irq, wake_req, 2'b00}, 32'h0);
        report_and_stop();
    end
endmodule : eii_bench

// file: eii_chan.sv
// One channel: pin combining, level sensing and edge detection
`timescale 1ns/1ns
module eii_chan #(
    parameter int NPINS = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Synchronised pins and their function selects
    input wire logic [NPINS-1:0] pin_sync,
    input wire logic [NPINS-1:0] pin_sel,
    // Configuration
    input wire logic edge_mode,
    input wire logic pol_high,
    // Result
    output logic set_cond,
    output logic level_active
);

    logic [NPINS-1:0] prev_reg;
    logic [NPINS-1:0] prev_next;
    logic and_all;
    logic or_all;
    logic low_found;
    logic low_cur;
    logic low_prev;

    if (NPINS < 1 || NPINS > 8) begin : g_chk
        $error("eii_chan: NPINS must lie between one and eight");
    end

    // Combine selected pins, pick the lowest for edge mode
    always_comb begin
        and_all = 1'b1;
        or_all = 1'b0;
        low_found = 1'b0;
        low_cur = 1'b0;
        low_prev = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
            if (pin_sel[i]) begin
                and_all = and_all & pin_sync[i];
                or_all = or_all | pin_sync[i];
                if (!low_found) begin
                    low_found = 1'b1;
                    low_cur = pin_sync[i];
                    low_prev = prev_reg[i];
                end
            end
        end
        // Active level per polarity
        level_active = pol_high ? or_all : ~and_all;
        // Edge: current sample differs from previous, ends at the chosen level
        if (edge_mode) begin
            set_cond = low_found && (low_cur != low_prev) && (low_cur == pol_high);
        end else begin
            set_cond = level_active;
        end
        prev_next = pin_sync;
    end

    // Previous sample for edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end

endmodule : eii_chan

// file: eii_pin_model.sv
// Far-side model: external pins and their function selects
`timescale 1ns/1ns
module eii_pin_model
    import eii_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Pins toward the block
    output logic [EII_NUM_PINS-1:0] pin_in,
    output logic [EII_NUM_PINS-1:0] pin_sel
);
    // Pins idle high with no function selected
    initial begin
        pin_in = {EII_NUM_PINS{1'b1}};
        pin_sel = {EII_NUM_PINS{1'b0}};
    end

    // New levels land just after a rising edge and then hold
    task automatic drive(input logic [EII_NUM_PINS-1:0] lvl, input logic [EII_NUM_PINS-1:0] sel);
        @(posedge sys_clk);
        pin_in <= lvl;
        pin_sel <= sel;
    endtask : drive
endmodule : eii_pin_model

// file: eii_pkg.sv
// Constants and types shared by the external interrupt input block
package eii_pkg;

    // Channel and pin counts
    localparam int EII_NUM_CH = 4;
    localparam int EII_NUM_PINS = 9;
    localparam int EII_PIN_BASE [EII_NUM_CH] = '{0, 2, 4, 6};
    localparam int EII_PIN_CNT [EII_NUM_CH] = '{2, 2, 2, 3};

    // Register byte addresses
    localparam logic [31:0] EII_OFF_FLAGS = 32'he01fc140;
    localparam logic [31:0] EII_OFF_WAKE = 32'he01fc144;
    localparam logic [31:0] EII_OFF_MODE = 32'he01fc148;
    localparam logic [31:0] EII_OFF_POL = 32'he01fc14c;
    localparam logic [31:0] EII_OFF_MASK = 32'he01fc150;

    // Reset values
    localparam logic [3:0] EII_RST_FLAGS = 4'h0;
    localparam logic [3:0] EII_RST_WAKE = 4'h0;
    localparam logic [3:0] EII_RST_MODE = 4'h0;
    localparam logic [3:0] EII_RST_POL = 4'h0;
    localparam logic [3:0] EII_RST_MASK = 4'h0;

    // Register selection after address decode
    typedef enum logic [2:0] {
        EII_SEL_FLAGS,
        EII_SEL_WAKE,
        EII_SEL_MODE,
        EII_SEL_POL,
        EII_SEL_MASK,
        EII_SEL_NONE
    } eii_sel_t;

endpackage : eii_pkg

// file: eii_sync.sv
// Two-stage synchroniser for the external interrupt pins
`timescale 1ns/1ns
module eii_sync #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage2_next;

    if (WIDTH < 1) begin : g_chk
        $error("eii_sync: WIDTH must be at least one");
    end

    // First stage is read by the second only
    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    // Register both stages
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;

endmodule : eii_sync

// file: eii_top.sv
// External interrupt inputs: APB registers, flags, wake and interrupt outputs
`timescale 1ns/1ns
module eii_top
    import eii_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins and their function selects
    input wire logic [EII_NUM_PINS-1:0] pin_in,
    input wire logic [EII_NUM_PINS-1:0] pin_sel,
    // Requests to the vectored controller, wake and summary interrupt
    output logic [EII_NUM_CH-1:0] vic_req,
    output logic wake_req,
    output logic irq
);

    // Register state
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [3:0] wake_reg;
    logic [3:0] wake_next;
    logic [3:0] mode_reg;
    logic [3:0] mode_next;
    logic [3:0] pol_reg;
    logic [3:0] pol_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    // Output flops
    logic irq_reg;
    logic irq_next;
    logic wakeo_reg;
    logic wakeo_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    // Internal
    logic [EII_NUM_PINS-1:0] pin_sync;
    logic [EII_NUM_CH-1:0] set_cond;
    logic [EII_NUM_CH-1:0] level_act;
    logic [3:0] clr_bits;
    logic acc_wr;
    eii_sel_t rd_sel;
    eii_sel_t wr_sel;

    // Address decode, used for read capture and write commit
    function automatic eii_sel_t eii_decode(input logic [31:0] addr);
        case (addr)
            EII_OFF_FLAGS: eii_decode = EII_SEL_FLAGS;
            EII_OFF_WAKE: eii_decode = EII_SEL_WAKE;
            EII_OFF_MODE: eii_decode = EII_SEL_MODE;
            EII_OFF_POL: eii_decode = EII_SEL_POL;
            EII_OFF_MASK: eii_decode = EII_SEL_MASK;
            default: eii_decode = EII_SEL_NONE;
        endcase
    endfunction : eii_decode

    // Pins enter the clock domain first
    eii_sync #(
        .WIDTH(EII_NUM_PINS)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // One sensing unit per channel
    for (genvar g = 0; g < EII_NUM_CH; g++) begin : g_ch
        eii_chan #(
            .NPINS(EII_PIN_CNT[g])
        ) u_chan (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_sync(pin_sync[EII_PIN_BASE[g] +: EII_PIN_CNT[g]]),
            .pin_sel(pin_sel[EII_PIN_BASE[g] +: EII_PIN_CNT[g]]),
            .edge_mode(mode_reg[g]),
            .pol_high(pol_reg[g]),
            .set_cond(set_cond[g]),
            .level_active(level_act[g])
        );
    end

    // APB: setup cycle captures read data, one access cycle with pready
    always_comb begin
        rd_sel = eii_decode(paddr);
        pready_next = psel & ~penable;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            case (rd_sel)
                EII_SEL_FLAGS: prdata_next = {28'h0, flags_reg};
                EII_SEL_WAKE: prdata_next = {28'h0, wake_reg};
                EII_SEL_MODE: prdata_next = {28'h0, mode_reg};
                EII_SEL_POL: prdata_next = {28'h0, pol_reg};
                EII_SEL_MASK: prdata_next = {28'h0, mask_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    // Write commit in the access cycle
    always_comb begin
        wr_sel = eii_decode(paddr);
        acc_wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
        clr_bits = 4'h0;
        wake_next = wake_reg;
        mode_next = mode_reg;
        pol_next = pol_reg;
        mask_next = mask_reg;
        if (acc_wr) begin
            case (wr_sel)
                EII_SEL_FLAGS: clr_bits = pwdata[3:0];
                EII_SEL_WAKE: wake_next = pwdata[3:0];
                EII_SEL_MODE: mode_next = pwdata[3:0];
                EII_SEL_POL: pol_next = pwdata[3:0];
                EII_SEL_MASK: mask_next = pwdata[3:0];
                default: clr_bits = 4'h0;
            endcase
        end
    end

    // Flags: set beats clear, so an active level survives a clear
    always_comb begin
        flags_next = (flags_reg & ~clr_bits) | set_cond;
        irq_next = |(flags_next & mask_next);
        wakeo_next = |(flags_next & wake_next);
    end

    // Register everything
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= EII_RST_FLAGS;
            wake_reg <= EII_RST_WAKE;
            mode_reg <= EII_RST_MODE;
            pol_reg <= EII_RST_POL;
            mask_reg <= EII_RST_MASK;
            irq_reg <= 1'b0;
            wakeo_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            wake_reg <= wake_next;
            mode_reg <= mode_next;
            pol_reg <= pol_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            wakeo_reg <= wakeo_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs straight from flops
    assign vic_req = flags_reg;
    assign wake_req = wakeo_reg;
    assign irq = irq_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence seq_setup;
        psel && !penable;
    endsequence

    sequence seq_access;
        psel && penable;
    endsequence

    sequence seq_flag_write;
        seq_access ##0 (pwrite && pready_reg && paddr == EII_OFF_FLAGS);
    endsequence

    AST_APB_ONE_WAIT: assert property (seq_setup |=> pready_reg)
        else $error("pready did not follow the setup cycle");

    AST_APB_NO_STRAY_READY: assert property (!(psel && !penable) |=> !pready_reg)
        else $error("pready high without a preceding setup cycle");

    AST_SET_STICKS: assert property ((set_cond != 4'h0) |=>
        ((flags_reg & $past(set_cond)) == $past(set_cond)))
        else $error("set condition did not raise its flag");

    AST_W1C_CLEARS: assert property (seq_flag_write |=>
        ((flags_reg & $past(pwdata[3:0]) & ~$past(set_cond)) == 4'h0))
        else $error("write of one did not clear the flag");

    AST_ZERO_KEEPS: assert property ((flags_reg != 4'h0) |=>
        (($past(flags_reg) & ~$past(clr_bits) & ~flags_reg) == 4'h0))
        else $error("flag dropped without a write of one");

    AST_LEVEL_HOLDS: assert property (
        seq_flag_write ##0 ((level_act & ~mode_reg) != 4'h0)
        |=> ((flags_reg & $past(level_act & ~mode_reg)) == $past(level_act & ~mode_reg)))
        else $error("clear took effect while level still active");

    AST_VIC_FOLLOWS: assert property ((set_cond != 4'h0) ##1 (clr_bits == 4'h0)
        |=> ((vic_req & $past(set_cond, 2)) == $past(set_cond, 2)))
        else $error("vic request dropped without a clear");

    AST_IRQ_MASKED: assert property (irq == |(flags_reg & mask_reg))
        else $error("interrupt output does not match masked flags");

    AST_WAKE_LEVEL: assert property (wake_req == |(flags_reg & wake_reg))
        else $error("wake output does not match enabled flags");

    AST_NO_SET_IDLE: assert property ((set_cond == 4'h0) && (clr_bits == 4'h0)
        |=> (flags_reg == $past(flags_reg)))
        else $error("flag changed with no cause");

    // Register commit and readback checks
    sequence seq_commit;
        seq_access ##0 (pwrite && pready_reg && !pslverr_reg);
    endsequence

    AST_PREADY_ONE_CYCLE: assert property (pready_reg |=> !pready_reg)
        else $error("pready stood for more than one cycle");

    AST_ERR_UNMAPPED: assert property (
        seq_setup ##0 (eii_decode(paddr) == EII_SEL_NONE) |=> (pready_reg && pslverr_reg))
        else $error("unmapped address did not raise pslverr");

    AST_ERR_IN_ACCESS: assert property (pslverr_reg |-> pready_reg)
        else $error("pslverr outside the access cycle");

    AST_RSVD_READ_ZERO: assert property (prdata_reg[31:4] == 28'h0)
        else $error("reserved read data bits not zero");

    AST_FLAGS_READ: assert property (
        seq_setup ##0 (paddr == EII_OFF_FLAGS) |=> (prdata_reg == {28'h0, $past(flags_reg)}))
        else $error("flag read data does not match the flags");

    AST_MODE_READ: assert property (
        seq_setup ##0 (paddr == EII_OFF_MODE) |=> (prdata_reg == {28'h0, $past(mode_reg)}))
        else $error("mode read data does not match the mode bits");

    AST_WAKE_WRITE: assert property (
        seq_commit ##0 (paddr == EII_OFF_WAKE) |=> (wake_reg == $past(pwdata[3:0])))
        else $error("wake enable write did not land");

    AST_MODE_WRITE: assert property (
        seq_commit ##0 (paddr == EII_OFF_MODE) |=> (mode_reg == $past(pwdata[3:0])))
        else $error("mode write did not land");

    AST_POL_WRITE: assert property (
        seq_commit ##0 (paddr == EII_OFF_POL) |=> (pol_reg == $past(pwdata[3:0])))
        else $error("polarity write did not land");

    AST_MASK_WRITE: assert property (
        seq_commit ##0 (paddr == EII_OFF_MASK) |=> (mask_reg == $past(pwdata[3:0])))
        else $error("mask write did not land");

    AST_CFG_HOLDS: assert property (
        !(psel && penable && pwrite && pready_reg && !pslverr_reg)
        |=> ($stable(wake_reg) && $stable(mode_reg) && $stable(pol_reg) && $stable(mask_reg)))
        else $error("configuration changed without a write");

    AST_LEVEL_SETS: assert property (
        ((level_act & ~mode_reg) != 4'h0)
        |=> ((flags_reg & $past(level_act & ~mode_reg)) == $past(level_act & ~mode_reg)))
        else $error("active level did not raise its flag");

    AST_SET_WINS: assert property (
        seq_flag_write ##0 ((set_cond & pwdata[3:0]) != 4'h0)
        |=> ((flags_reg & $past(set_cond & pwdata[3:0])) == $past(set_cond & pwdata[3:0])))
        else $error("clear won over a set in the same cycle");

    // Per-channel checks on the sensing units
    for (genvar g = 0; g < EII_NUM_CH; g++) begin : g_chk_ch
        AST_SET_NEEDS_SEL: assert property (
            set_cond[g] |-> (pin_sel[EII_PIN_BASE[g] +: EII_PIN_CNT[g]] != '0))
            else $error("channel set without a selected pin");

        AST_EDGE_NEEDS_CHANGE: assert property (
            (mode_reg[g] && $stable(pin_sync)) |-> !set_cond[g])
            else $error("edge set without a pin transition");

        AST_EDGE_ONE_SHOT: assert property (
            (mode_reg[g] && set_cond[g])
            ##1 (mode_reg[g] && $stable(pol_reg[g]) && $stable(pin_sel))
            |-> !set_cond[g])
            else $error("edge condition stood for two cycles");
    end

endmodule : eii_top
